// ### inc/sfpi_pkg.sv
// shared constants of the serial flash pin interface, both ends
package sfpi_pkg;
   // instruction codes
   localparam logic [7:0] OP_ENTER_QUAD = 8'h35;
   localparam logic [7:0] OP_EXIT_QUAD = 8'hf5;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;
   // status layout
   localparam int SB_LOCK = 7;
   localparam int SB_QUAD = 6;
   localparam logic [7:0] STATUS_WR_MASK = 8'hfc;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // lane roles
   localparam int LANE_DI = 0;
   localparam int LANE_DO = 1;
   localparam int LANE_WP = 2;
   localparam int LANE_HOLD = 3;
   localparam logic [3:0] OE_NONE = 4'h0;
   localparam logic [3:0] OE_SO = 4'h2;
   localparam logic [3:0] OE_ALL = 4'hf;
   localparam logic [3:0] OE_HOST_SINGLE = 4'hd;
   // bit counting
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] STEP_SINGLE = 4'h1;
   localparam logic [3:0] STEP_QUAD = 4'h4;
   localparam logic [4:0] HBITS_ONE = 5'h08;
   localparam logic [4:0] HBITS_TWO = 5'h10;
   localparam logic [4:0] HW_SINGLE = 5'h01;
   localparam logic [4:0] HW_QUAD = 5'h04;
   // controller registers (byte addresses)
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_CMD = 12'h004;
   localparam logic [11:0] REG_STAT = 12'h008;
   localparam int CTRL_QUAD = 0;
   localparam int CTRL_HOLD_N = 1;
   localparam int CTRL_WP_N = 2;
   localparam int CTRL_CPOL = 3;
   localparam logic [3:0] CTRL_RESET = 4'h6;
   localparam logic [1:0] KIND_OP = 2'h0;
   localparam logic [1:0] KIND_WRITE = 2'h1;
   localparam logic [1:0] KIND_READ = 2'h2;
   localparam logic [15:0] SCK_HALF_DEFAULT = 16'h0008;
endpackage

// ### inc/sfpi_link_if.sv
// pin bundle between controller and flash, with resolved lane levels
`timescale 1ns/1ns
interface sfpi_link_if;
   logic sck;
   logic cs_n;
   logic [3:0] h_out;
   logic [3:0] h_oe;
   logic [3:0] f_out;
   logic [3:0] f_oe;
   logic [3:0] lane;

   // undriven lanes float high, as with board pull-ups
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lane[i] = h_oe[i] ? h_out[i] : (f_oe[i] ? f_out[i] : 1'b1);
      end
   end

   modport ctrl(output sck, output cs_n, output h_out, output h_oe, input lane);
   modport flash(input sck, input cs_n, input lane, output f_out, output f_oe);
endinterface

// ### rtl/sfpi_flash_end.sv
// flash side pin front end: select, lane modes, pause and status protection
// Overview of operation
// - chip select high: deselect, all outputs floating
// - deselected means low-power standby
// - select on low chip select, accept traffic
// - input bits ignored while chip select high
// - after power-up, need high-to-low select first
// - single-line inputs sampled on rising clock
// - single-line outputs change on falling clock
// - quad lanes bidirectional, same edges
// - quad uses protect and pause pins as lanes
// - lock set, protect low: refuse status writes
// - lock clear: status always writable
// - quad enable disables write-protect function
// - pause keeps serial position, no reset
// - paused and selected: output floating
// - resume when pause pin returns high
// - quad enable disables pause function
// - 35h enters quad mode, f5h leaves
// - reset returns to single-line mode
// - clock idle low or high both work
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ns
module sfpi_flash_end
   import sfpi_pkg::*;
#(
   parameter logic [7:0] STATUS_INIT = STATUS_RESET
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   sfpi_link_if.flash link,
   output logic [7:0] o_status,
   output logic o_standby,
   output logic o_quad_mode,
   output logic [7:0] o_opcode,
   output logic o_opcode_valid,
   output logic o_paused,
   output logic o_write_refused
);

   typedef enum logic [4:0] {
      DEV_IDLE = 5'b00001,
      DEV_CMD = 5'b00010,
      DEV_WDATA = 5'b00100,
      DEV_RDATA = 5'b01000,
      DEV_SKIP = 5'b10000
   } sfpi_dev_fsm_t;

   typedef struct packed {
      logic [2:0] cs_p;
      logic [2:0] sck_p;
      logic [3:0] ln_a;
      logic [3:0] ln_b;
      logic armed;
      logic sel;
      sfpi_dev_fsm_t fsm;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [7:0] status;
      logic qmode;
      logic rst_arm;
      logic [3:0] d_out;
      logic [3:0] d_oe;
      logic [7:0] opcode;
      logic op_v;
      logic refused;
      logic paused;
      logic standby;
   } sfpi_dev_state_t;

   sfpi_dev_state_t q;
   sfpi_dev_state_t n;
   logic cs_hi;
   logic rise;
   logic fall;
   logic hold_act;
   logic done;
   logic prot;
   logic [3:0] step;
   logic [3:0] cnt_nx;
   logic [7:0] shin;

   // next-state logic; edges come from the synchronised clock pin
   always_comb begin
      n = q;
      cs_hi = q.cs_p[1];
      rise = q.sck_p[1] & ~q.sck_p[2];
      fall = ~q.sck_p[1] & q.sck_p[2];
      // pause pin only counts outside quad use
      hold_act = ~q.status[SB_QUAD] & ~q.qmode & ~q.ln_b[LANE_HOLD] & q.sel;
      step = q.qmode ? STEP_QUAD : STEP_SINGLE;
      cnt_nx = q.cnt + step;
      done = (cnt_nx == BYTE_BITS);
      shin = q.qmode ? {q.sh[3:0], q.ln_b} : {q.sh[6:0], q.ln_b[LANE_DI]};
      // protect pin has no say once it carries data
      prot = q.status[SB_LOCK] & ~q.status[SB_QUAD] & ~q.qmode
             & ~q.ln_b[LANE_WP];
      n.cs_p = {q.cs_p[1:0], link.cs_n};
      n.sck_p = {q.sck_p[1:0], link.sck};
      n.ln_a = link.lane;
      n.ln_b = q.ln_a;
      n.op_v = 1'b0;
      n.refused = 1'b0;
      if (cs_hi) begin
         // deselected: float, stand by, drop any partial byte
         n.armed = 1'b1;
         n.sel = 1'b0;
         n.fsm = DEV_IDLE;
         n.cnt = 4'h0;
         n.d_oe = OE_NONE;
         n.standby = 1'b1;
         n.paused = 1'b0;
      end else if (!q.sel) begin
         // only a seen high-to-low step selects
         if (q.armed && q.cs_p[2]) begin
            n.sel = 1'b1;
            n.standby = 1'b0;
            n.fsm = DEV_CMD;
            n.cnt = 4'h0;
         end
      end else begin
         n.paused = hold_act;
         if (hold_act) begin
            // clock edges ignored, counter and shifter kept
            n.d_oe = OE_NONE;
         end else begin
            if (rise) begin
               n.sh = shin;
               n.cnt = done ? 4'h0 : cnt_nx;
               case (q.fsm)
                  DEV_CMD: begin
                     if (done) begin
                        n.opcode = shin;
                        n.op_v = 1'b1;
                        n.rst_arm = 1'b0;
                        n.fsm = DEV_SKIP;
                        case (shin)
                           OP_ENTER_QUAD: begin
                              n.qmode = 1'b1;
                           end
                           OP_EXIT_QUAD: begin
                              n.qmode = 1'b0;
                           end
                           OP_WRITE_STATUS: begin
                              n.fsm = DEV_WDATA;
                           end
                           OP_READ_STATUS: begin
                              n.tx = q.status;
                              n.fsm = DEV_RDATA;
                           end
                           OP_RESET_ENABLE: begin
                              n.rst_arm = 1'b1;
                           end
                           OP_RESET: begin
                              if (q.rst_arm) begin
                                 n.qmode = 1'b0;
                              end
                           end
                           default: begin
                              n.fsm = DEV_SKIP;
                           end
                        endcase
                     end
                  end
                  DEV_WDATA: begin
                     if (done) begin
                        n.fsm = DEV_SKIP;
                        if (prot) begin
                           n.refused = 1'b1;
                        end else begin
                           n.status = (q.status & ~STATUS_WR_MASK)
                                      | (shin & STATUS_WR_MASK);
                        end
                     end
                  end
                  DEV_RDATA: begin
                     n.fsm = DEV_RDATA;
                  end
                  DEV_SKIP: begin
                     n.fsm = DEV_SKIP;
                  end
                  default: begin
                     n.fsm = DEV_SKIP;
                  end
               endcase
            end
            // status repeats for as long as the host clocks
            if (fall && q.fsm == DEV_RDATA) begin
               if (q.qmode) begin
                  n.d_out = q.tx[7:4];
                  n.d_oe = OE_ALL;
                  n.tx = {q.tx[3:0], q.tx[7:4]};
               end else begin
                  n.d_out = {2'b00, q.tx[7], 1'b0};
                  n.d_oe = OE_SO;
                  n.tx = {q.tx[6:0], q.tx[7]};
               end
            end
         end
      end
   end

   // state register; sync pipes reset low so a real high must arrive
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         q <= '0;
         q.fsm <= DEV_IDLE;
         q.status <= STATUS_INIT;
         q.standby <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign link.f_out = q.d_out;
   assign link.f_oe = q.d_oe;
   assign o_status = q.status;
   assign o_standby = q.standby;
   assign o_quad_mode = q.qmode;
   assign o_opcode = q.opcode;
   assign o_opcode_valid = q.op_v;
   assign o_paused = q.paused;
   assign o_write_refused = q.refused;

endmodule // sfpi_flash_end

// ### rtl/sfpi_host_end.sv
// controller side: apb registers, clock divider and lane sequencer
`timescale 1ns/1ns
module sfpi_host_end
   import sfpi_pkg::*;
#(
   parameter logic [15:0] SCK_HALF = SCK_HALF_DEFAULT
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_busy,
   sfpi_link_if.ctrl link
);

   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_LEAD = 5'b00010,
      H_LOW = 5'b00100,
      H_HIGH = 5'b01000,
      H_TAIL = 5'b10000
   } sfpi_host_fsm_t;

   typedef struct packed {
      logic [3:0] ctrl;
      logic [17:0] cmd;
      logic busy;
      sfpi_host_fsm_t fsm;
      logic [15:0] div;
      logic [4:0] bits;
      logic [15:0] sh;
      logic [7:0] rx;
      logic sck;
      logic cs_n;
      logic [3:0] h_out;
      logic [3:0] h_oe;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sfpi_host_state_t;

   sfpi_host_state_t q;
   sfpi_host_state_t n;
   logic quad;
   logic rd;
   logic tick;
   logic paused;
   logic wr_ok;

   // lane drive for the next bit; read phase releases the data lanes
   function automatic logic [7:0] drive(input logic [15:0] sh, input logic rd_ph,
                                        input logic [3:0] ctl);
      logic [7:0] r;
      r = 8'h00;
      if (ctl[CTRL_QUAD]) begin
         r = rd_ph ? {OE_NONE, 4'h0} : {OE_ALL, sh[15:12]};
      end else begin
         r = {(rd_ph ? (OE_HOST_SINGLE & ~4'h1) : OE_HOST_SINGLE),
              ctl[CTRL_HOLD_N], ctl[CTRL_WP_N], 1'b0, sh[15]};
      end
      return r;
   endfunction

   always_comb begin
      n = q;
      quad = q.ctrl[CTRL_QUAD];
      rd = (q.cmd[17:16] == KIND_READ) && (q.bits <= HBITS_ONE);
      tick = (q.div == SCK_HALF - 16'h0001);
      // pausing the flash also stalls our own sequencer
      paused = ~quad & ~q.ctrl[CTRL_HOLD_N];
      wr_ok = i_psel & i_penable & q.pready & i_pwrite;
      // apb: pready rises in the second access cycle
      n.pready = i_psel & i_penable & ~q.pready;
      n.pslverr = 1'b0;
      if (i_psel && i_penable && !q.pready) begin
         case (i_paddr)
            REG_CTRL: n.prdata = {28'h0, q.ctrl};
            REG_CMD: n.prdata = {14'h0, q.cmd};
            REG_STAT: n.prdata = {16'h0, q.rx, 7'h0, q.busy};
            default: begin
               n.prdata = 32'h0;
               n.pslverr = 1'b1;
            end
         endcase
      end
      if (wr_ok && i_paddr == REG_CTRL) begin
         n.ctrl = i_pwdata[3:0];
      end
      // a command write while busy is dropped
      if (wr_ok && i_paddr == REG_CMD && !q.busy) begin
         n.cmd = i_pwdata[17:0];
         // opcode byte leaves first, data byte after it
         n.sh = {i_pwdata[7:0], i_pwdata[15:8]};
         n.bits = (i_pwdata[17:16] == KIND_OP) ? HBITS_ONE : HBITS_TWO;
         n.busy = 1'b1;
         n.cs_n = 1'b0;
         n.sck = q.ctrl[CTRL_CPOL];
         n.div = 16'h0;
         n.fsm = H_LEAD;
      end
      if (q.fsm != H_IDLE && !(paused && (q.fsm == H_LOW || q.fsm == H_HIGH))) begin
         n.div = tick ? 16'h0 : q.div + 16'h0001;
      end
      case (q.fsm)
         H_IDLE: begin
            n.h_oe = quad ? OE_NONE : OE_HOST_SINGLE;
            n.h_out = {q.ctrl[CTRL_HOLD_N], q.ctrl[CTRL_WP_N], 2'b00};
            n.sck = q.ctrl[CTRL_CPOL];
         end
         H_LEAD: begin
            if (tick) begin
               {n.h_oe, n.h_out} = drive(q.sh, rd, q.ctrl);
               n.sck = 1'b0;
               n.fsm = H_LOW;
            end
         end
         H_LOW: begin
            if (tick && !paused) begin
               n.sck = 1'b1;
               n.sh = quad ? {q.sh[11:0], 4'h0} : {q.sh[14:0], 1'b0};
               n.bits = q.bits - (quad ? HW_QUAD : HW_SINGLE);
               if (rd) begin
                  n.rx = quad ? {q.rx[3:0], link.lane} : {q.rx[6:0], link.lane[LANE_DO]};
               end
               n.fsm = H_HIGH;
            end
         end
         H_HIGH: begin
            if (tick && !paused) begin
               if (q.bits == 5'h00) begin
                  n.sck = q.ctrl[CTRL_CPOL];
                  n.fsm = H_TAIL;
               end else begin
                  {n.h_oe, n.h_out} = drive(q.sh, rd, q.ctrl);
                  n.sck = 1'b0;
                  n.fsm = H_LOW;
               end
            end
         end
         H_TAIL: begin
            if (tick) begin
               n.cs_n = 1'b1;
               n.busy = 1'b0;
               n.fsm = H_IDLE;
            end
         end
         default: begin
            n.fsm = H_IDLE;
         end
      endcase
      // pause and protect pins follow ctrl at once; waiting for the next
      // bit would leave a stalled sequencer unable to raise the pause
      if (!quad) begin
         n.h_out[LANE_HOLD] = q.ctrl[CTRL_HOLD_N];
         n.h_out[LANE_WP] = q.ctrl[CTRL_WP_N];
      end
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         q <= '0;
         q.ctrl <= CTRL_RESET;
         q.fsm <= H_IDLE;
         q.cs_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign link.sck = q.sck;
   assign link.cs_n = q.cs_n;
   assign link.h_out = q.h_out;
   assign link.h_oe = q.h_oe;
   assign o_prdata = q.prdata;
   assign o_pready = q.pready;
   assign o_pslverr = q.pslverr;
   assign o_busy = q.busy;

endmodule // sfpi_host_end

// ### testbench/sfpi_link_asserts.sv
// link checker: watches the pin bundle between the two ends
`timescale 1ns/1ns
module sfpi_link_asserts (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] h_out,
   input wire logic [3:0] h_oe,
   input wire logic [3:0] f_out,
   input wire logic [3:0] f_oe,
   input wire logic [3:0] lane
);
   // one domain, so one clock and one disable for every property
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   // deselected: flash lets go of every lane once the select has settled
   a_deselect_float: assert property (cs_n [*5] |-> f_oe == 4'h0)
      else $error("flash drives a lane while deselected");
   // flash enables only the single output lane or all four lanes
   a_oe_shape: assert property (f_oe == 4'h0 || f_oe == 4'h2 || f_oe == 4'hf)
      else $error("flash lane enable pattern illegal");
   // lanes are turned around without both ends driving at once
   a_no_contention: assert property ((h_oe & f_oe) == 4'h0)
      else $error("both ends drive one lane");
   // flash output data moves only in the low half of the clock
   a_out_on_fall: assert property (
      (|f_oe && $past(|f_oe) && $changed(f_out & f_oe)) |-> !sck)
      else $error("flash output changed while clock high");
   // host data stands still across the sampling edge
   a_in_stable_rise: assert property (($rose(sck) && !cs_n) |-> $stable(h_out[2:0] & h_oe[2:0]))
      else $error("host data moved at clock rise");
   // clock keeps its idle level a while after select falls
   a_idle_after_sel: assert property ($fell(cs_n) |-> $stable(sck) [*4])
      else $error("clock moved right after select");
   // a select must be followed by clock activity within a bounded time
   a_select_starts: assert property ($fell(cs_n) |-> ##[1:20] $changed(sck))
      else $error("no clock activity after select");
   // paused while selected in single mode: output lane floats
   a_hold_float: assert property (
      (!cs_n && h_oe == 4'hd && !lane[3]) [*5] |-> f_oe == 4'h0)
      else $error("flash drives output while paused");
endmodule // sfpi_link_asserts

// ### testbench/serial_flash_pin_interface_tb_top.sv
// self-checking bench: host and flash ends joined by the link interface
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module serial_flash_pin_interface_tb_top;
   import sfpi_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, busy, standby, quad_mode, opcode_valid, paused, refused;
   logic [7:0] status, opcode, d1, d2, d3, d4;
   logic [7:0] exp_now;
   logic [7:0] exp_op[$];
   int fail_count = 0;
   int samples_checked = 0;
   int refused_seen = 0;
   int cycles = 0;

   always #4 i_core_clk = ~i_core_clk;

   sfpi_link_if link();
   sfpi_host_end #(.SCK_HALF(16'h0006)) sfpi_host_end_inst (.i_core_clk(i_core_clk),
      .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_busy(busy), .link(link.ctrl));
   sfpi_flash_end sfpi_flash_end_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .link(link.flash), .o_status(status), .o_standby(standby), .o_quad_mode(quad_mode),
      .o_opcode(opcode), .o_opcode_valid(opcode_valid), .o_paused(paused),
      .o_write_refused(refused));
   sfpi_link_asserts sfpi_link_asserts_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .sck(link.sck), .cs_n(link.cs_n), .h_out(link.h_out), .h_oe(link.h_oe),
      .f_out(link.f_out), .f_oe(link.f_oe), .lane(link.lane));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_core_clk);
      penable <= 1'b1;
      do @(posedge i_core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_core_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, a, d, rd, e);
   endtask

   // poll busy; the global cycle ceiling cuts a hang short
   task automatic wait_idle();
      logic [31:0] rd;
      logic e;
      do apb(1'b0, REG_STAT, 32'h0, rd, e); while (rd[0] !== 1'b0);
   endtask

   task automatic cmd(input logic [1:0] k, input logic [7:0] op, input logic [7:0] d);
      exp_op.push_back(op);
      wr(REG_CMD, {14'h0, k, d, op});
      wait_idle();
   endtask

   task automatic rd_status(output logic [7:0] v);
      logic [31:0] rd;
      logic e;
      cmd(KIND_READ, OP_READ_STATUS, 8'h00);
      apb(1'b0, REG_STAT, 32'h0, rd, e);
      v = rd[15:8];
   endtask

   // watcher: each reported opcode is matched to the oldest note
   always @(posedge i_core_clk) begin
      // take the note off once, so a mismatch does not consume two
      if (opcode_valid === 1'b1) begin
         exp_now = (exp_op.size() > 0) ? exp_op.pop_front() : 8'hxx;
         `CHK("opcode", exp_now, opcode)
      end
      if (refused === 1'b1)
         refused_seen++;
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      logic [31:0] rd;
      logic e;
      logic [7:0] v;
      void'($urandom(32'h40a067a9));
      repeat (16) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      @(posedge i_core_clk);
      `CHK("reset status", STATUS_RESET, status)
      `CHK("reset standby", 1'b1, standby)
      `CHK("reset quad", 1'b0, quad_mode)
      apb(1'b0, REG_CTRL, 32'h0, rd, e);
      `CHK("ctrl reset", {28'h0, CTRL_RESET}, rd)
      $display("test reset done");
      // lock clear: write takes, lock set for the next test
      d1 = 8'($urandom() & 32'h3c) | 8'h80;
      cmd(KIND_WRITE, OP_WRITE_STATUS, d1);
      `CHK("status open", d1, status)
      `CHK("standby idle", 1'b1, standby)
      // lock set and protect low: refused silently
      wr(REG_CTRL, 32'h2);
      cmd(KIND_WRITE, OP_WRITE_STATUS, 8'h00);
      `CHK("status kept", d1, status)
      `CHK("refused pulse", 1, refused_seen)
      // protect high again: allowed, lock cleared
      wr(REG_CTRL, 32'h6);
      d2 = 8'($urandom() & 32'h3c);
      cmd(KIND_WRITE, OP_WRITE_STATUS, d2);
      `CHK("status unlocked", d2, status)
      rd_status(v);
      `CHK("read status", d2, v)
      $display("test protect done");
      // clock idle high, protect low but lock clear
      wr(REG_CTRL, 32'ha);
      d3 = 8'($urandom() & 32'h3c);
      cmd(KIND_WRITE, OP_WRITE_STATUS, d3);
      `CHK("status mode3", d3, status)
      rd_status(v);
      `CHK("read mode3", d3, v)
      wr(REG_CTRL, 32'h6);
      $display("test mode3 done");
      // pause in mid transfer, then resume
      d4 = 8'($urandom() & 32'h3c);
      exp_op.push_back(OP_WRITE_STATUS);
      wr(REG_CMD, {14'h0, KIND_WRITE, d4, OP_WRITE_STATUS});
      repeat (30) @(posedge i_core_clk);
      wr(REG_CTRL, 32'h4);
      repeat (20) @(posedge i_core_clk);
      `CHK("paused", 1'b1, paused)
      `CHK("selected", 1'b0, standby)
      `CHK("host stalled", 1'b1, busy)
      wr(REG_CTRL, 32'h6);
      wait_idle();
      `CHK("status resumed", d4, status)
      `CHK("pause ended", 1'b0, paused)
      $display("test pause done");
      // quad instruction mode: enter, read on four lanes, leave, reset
      cmd(KIND_OP, OP_ENTER_QUAD, 8'h00);
      `CHK("quad on", 1'b1, quad_mode)
      wr(REG_CTRL, 32'h7);
      rd_status(v);
      `CHK("quad read", d4, v)
      cmd(KIND_OP, OP_EXIT_QUAD, 8'h00);
      `CHK("quad off", 1'b0, quad_mode)
      wr(REG_CTRL, 32'h6);
      cmd(KIND_OP, OP_ENTER_QUAD, 8'h00);
      wr(REG_CTRL, 32'h7);
      cmd(KIND_OP, OP_RESET_ENABLE, 8'h00);
      cmd(KIND_OP, OP_RESET, 8'h00);
      `CHK("quad reset", 1'b0, quad_mode)
      wr(REG_CTRL, 32'h6);
      $display("test quad done");
      // power reset while in quad mode: single again, fresh select needed
      cmd(KIND_OP, OP_ENTER_QUAD, 8'h00);
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      @(posedge i_core_clk);
      `CHK("power reset quad", 1'b0, quad_mode)
      `CHK("power reset standby", 1'b1, standby)
      $display("test power reset done");
      // quad pin enable set: protect pin no longer guards the status
      cmd(KIND_WRITE, OP_WRITE_STATUS, 8'hc0);
      wr(REG_CTRL, 32'h2);
      cmd(KIND_WRITE, OP_WRITE_STATUS, 8'h00);
      `CHK("quad enable unprotects", 8'h00, status)
      `CHK("no new refusal", 1, refused_seen)
      `CHK("busy low", 1'b0, busy)
      wr(REG_CTRL, 32'h6);
      $display("test quad enable done");
      // unmapped register address
      apb(1'b0, 12'h010, 32'h0, rd, e);
      `CHK("unmapped err", 1'b1, e)
      `CHK("notes left", 0, exp_op.size())
      $display("test apb done");
      report_and_stop();
   end
endmodule // serial_flash_pin_interface_tb_top
